// ===== pacc_checker_asserts.sv
/*
  port assertions of the pulse accumulator.
  assumes ctrl 0x80, flags 0x84, count 0x88.
*/
`timescale 1ns/1ns
module pacc_checker #(
  parameter int unsigned CHANNELS = 8
) (
  // clock and reset
  input wire logic                    pclk,
  input wire logic                    presetn,
  // inputs
  input wire pacc_pkg::pacc_apb_req_s apb_req,
  input wire pacc_pkg::pacc_timer_s   timer_in,
  input wire logic [15:0]             free_counter,
  input wire logic [CHANNELS-1:0]     channel_mode_select,
  input wire logic [CHANNELS-1:0]     capture_strobe,
  input wire logic                    channel7_pin,
  // outputs
  input wire logic                    counter_tick,
  input wire logic [CHANNELS*16-1:0]  compare_values,
  input wire logic                    accum_overflow_irq,
  input wire logic                    accum_input_irq
);
  import pacc_pkg::*;
  logic [7:0] ctl_q;
  logic       pin_q;
  logic [3:0] calm_q;
  logic       acc;
  logic       quiet;
  assign acc = apb_req.psel & apb_req.penable;
  // no flag can be set while the pin is settled and no tick is due
  assign quiet = (calm_q > 4'h7) & ~timer_in.div64_tick;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_q  <= 8'h00;
      pin_q  <= 1'b0;
      calm_q <= 4'h0;
    end else begin
      if (acc && apb_req.pwrite && apb_req.paddr == 8'h80) begin
        ctl_q <= apb_req.pwdata[7:0] & 8'h7F;
      end
      pin_q  <= channel7_pin;
      calm_q <= (channel7_pin != pin_q) ? 4'h0
              : calm_q + {3'h0, calm_q != 4'hF};
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  cap_load_a: assert property (
    capture_strobe[0] && !channel_mode_select[0]
    |=> compare_values[15:0] == $past(free_counter))
    else $error("capture value wrong");
  cap_hold_a: assert property (
    !channel_mode_select[0] && !capture_strobe[0]
    |=> $stable(compare_values[15:0]))
    else $error("capture channel changed");
  chan_reset_a: assert property (
    $rose(presetn) |-> compare_values == '0)
    else $error("channel not zero");
  presc_clk_a: assert property (
    timer_in.timer_enable && (!ctl_q[6] || ctl_q[3:2] == 2'b00)
    |-> counter_tick == timer_in.prescale_tick)
    else $error("counter clock not prescaler");
  ovf_irq_a: assert property (
    !ctl_q[1] |-> !accum_overflow_irq)
    else $error("overflow request unmasked");
  in_irq_a: assert property (
    !ctl_q[0] |-> !accum_input_irq)
    else $error("input request unmasked");
  pin_sync_a: assert property (
    $rose(accum_input_irq) && $past(ctl_q[0])
    |-> calm_q >= 4'h2 && calm_q <= 4'h4)
    else $error("input flag timing");
  fast_clr_a: assert property (
    acc && apb_req.paddr == 8'h88 && timer_in.fast_flag_clear && quiet
    |=> !accum_overflow_irq && !accum_input_irq)
    else $error("fast clear missed");
  w1c_a: assert property (
    acc && apb_req.pwrite && apb_req.paddr == 8'h84 && quiet
    && apb_req.pwdata[1:0] == 2'b11 && timer_in.timer_enable
    |=> !accum_overflow_irq && !accum_input_irq)
    else $error("flag clear missed");
  cover property ($rose(accum_overflow_irq));
  cover property ($rose(accum_input_irq));
  cover property (capture_strobe[0] && !channel_mode_select[0]);
endmodule : pacc_checker

bind pacc_top pacc_checker #(.CHANNELS(CHANNELS)) u_pacc_checker (
  .pclk(pclk), .presetn(presetn), .apb_req(apb_req),
  .timer_in(timer_in), .free_counter(free_counter),
  .channel_mode_select(channel_mode_select),
  .capture_strobe(capture_strobe), .channel7_pin(channel7_pin),
  .counter_tick(counter_tick), .compare_values(compare_values),
  .accum_overflow_irq(accum_overflow_irq),
  .accum_input_irq(accum_input_irq));

// ===== pacc_map.svh
/*
  register offsets, field positions and reset values of the pulse
  accumulator and channel value registers.
  assumes an APB slave with 32-bit words, one register per aligned word.
*/
// What this block does
// - capture counter on input, else compare value
// - input capture channel ignores software writes
// - channel value registers reset to zero
// - accum_enable works independently of timer_enable
// - accum_mode picks event or gated mode
// - accum_polarity picks counted edge in event mode
// - gated mode counts div64 pulses on level
// - no gated pulses while timer disabled
// - counter_clock_source picks main counter clock
// - accumulator off means prescaler clock always
// - clock source changes immediately after write
// - overflow request equals enable and flag
// - input request equals enable and flag
// - fast clear: count access clears flags
// - write one clears flag, timer enabled
// - rollover to zero sets overflow flag
// - counted or trailing edge sets input flag
// - count holds edges, software read/write
// - pin synchronised before edge detection
// - accumulator input shares channel 7 pin
// - gated mode count holds div64 pulses
`ifndef PACC_MAP_SVH
`define PACC_MAP_SVH
`define PACC_ADDR_CTRL   8'h20
`define PACC_ADDR_FLAGS  8'h21
`define PACC_ADDR_COUNT  8'h22
`define PACC_ADDR_CHAN0  8'h10
`define PACC_CTRL_EN     6
`define PACC_CTRL_MODE   5
`define PACC_CTRL_POL    4
`define PACC_CTRL_CLK_HI 3
`define PACC_CTRL_CLK_LO 2
`define PACC_CTRL_OVI    1
`define PACC_CTRL_INI    0
`define PACC_CTRL_MASK   8'h7F
`define PACC_FLAG_OVF    1
`define PACC_FLAG_INF    0
`define PACC_CTRL_RESET  8'h00
`define PACC_CHAN_RESET  16'h0000
`define PACC_COUNT_RESET 16'h0000
`define PACC_COUNT_MAX   16'hFFFF
`define PACC_DIV256_BITS 8
`define PACC_DIV65536_BITS 16
`endif

// ===== pacc_pin_drv.sv
/*
  source of the channel 7 pin signal.
  assumes the bench calls its tasks.
*/
`timescale 1ns/1ns
module pacc_pin_drv (
  // pin
  output logic pin
);
  initial pin = 1'b0;
  // odd delay moves pin edges off the bus clock edges; over long pulse runs the 37 ns steps drift onto them
  task automatic set_level(input logic v);
    #37 pin = v;
  endtask : set_level
  task automatic pulses(input int n, input int w);
    repeat (n) begin
      set_level(1'b1);
      #(w * 100);
      set_level(1'b0);
      #(w * 100);
    end
  endtask : pulses
endmodule : pacc_pin_drv

// ===== pacc_pin_sync.sv
/*
  synchroniser and edge detector for the channel 7 pin.
  assumes pin_in is asynchronous to pclk.
*/
`timescale 1ns/1ns
module pacc_pin_sync (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // pin
  input  wire logic pin_in,
  // detected
  output logic      level,
  output logic      rise,
  output logic      fall
);
  import pacc_pkg::*;

  pacc_sync_s s_q;
  pacc_sync_s s_d;

  always_comb begin
    s_d    = s_q;
    s_d.q1 = pin_in;
    s_d.q2 = s_q.q1;
    // q3 takes q2 on every clock: it is the level one cycle behind q2
    s_d.q3 = s_q.q2;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // previous value is q3; change counts once q2 and q3 differ
  assign level = s_q.q3;
  assign rise  = s_q.q2 & ~s_q.q3;
  assign fall  = ~s_q.q2 & s_q.q3;
endmodule : pacc_pin_sync

// ===== pacc_pkg.sv
/*
  types of the pulse accumulator block.
  assumes pacc_map.svh supplies the numeric constants.
*/
package pacc_pkg;
  typedef enum logic [1:0] {
    PACC_SRC_PRESCALE,
    PACC_SRC_ACLK,
    PACC_SRC_ACLK256,
    PACC_SRC_ACLK65536
  } pacc_src_e;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } pacc_apb_req_s;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } pacc_apb_rsp_s;

  typedef struct packed {
    logic timer_enable;
    logic fast_flag_clear;
    logic prescale_tick;
    logic div64_tick;
  } pacc_timer_s;

  typedef struct packed {
    logic q1;
    logic q2;
    logic q3;
  } pacc_sync_s;
endpackage : pacc_pkg

// ===== pacc_top.sv
/*
  pulse accumulator with channel capture/compare value registers.
  assumes an APB master on pclk, and the rest of the timer supplying
  the free-running counter, capture strobes, prescaler and div64 ticks.
*/
`timescale 1ns/1ns
`include "pacc_map.svh"
module pacc_top #(
  parameter int unsigned CHANNELS = 8
) (
  // clock and reset
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  // apb
  input  wire pacc_pkg::pacc_apb_req_s apb_req,
  output pacc_pkg::pacc_apb_rsp_s      apb_rsp,
  // timer core
  input  wire pacc_pkg::pacc_timer_s   timer_in,
  input  wire logic [15:0]             free_counter,
  input  wire logic [CHANNELS-1:0]     channel_mode_select,
  input  wire logic [CHANNELS-1:0]     capture_strobe,
  // pin
  input  wire logic                    channel7_pin,
  // outputs to timer core
  output logic                         counter_tick,
  output logic [CHANNELS*16-1:0]       compare_values,
  // interrupt requests
  output logic                         accum_overflow_irq,
  output logic                         accum_input_irq
);
  import pacc_pkg::*;

  typedef struct packed {
    logic [7:0]               ctrl;
    logic                     ovf;
    logic                     inf;
    logic [15:0]              count;
    logic [15:0]              div_cnt;
    logic [CHANNELS-1:0][15:0] chan;
    logic [31:0]              rdata;
  } pacc_state_s;

  pacc_state_s st_q;
  pacc_state_s st_d;

  logic pin_level;
  logic pin_rise;
  logic pin_fall;

  pacc_pin_sync u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .pin_in  (channel7_pin),
    .level   (pin_level),
    .rise    (pin_rise),
    .fall    (pin_fall)
  );

  function automatic logic is_chan(input logic [7:0] a);
    return (a >= `PACC_ADDR_CHAN0) &&
           (a < `PACC_ADDR_CHAN0 + 8'(CHANNELS));
  endfunction : is_chan

  function automatic int unsigned chan_idx(input logic [7:0] a);
    return int'(a - `PACC_ADDR_CHAN0);
  endfunction : chan_idx

  logic        access;
  logic        wr;
  logic        rd;
  logic [7:0]  word;
  logic        en;
  logic        gated;
  logic        pol;
  logic        count_tick;
  logic        in_event;
  logic        gate_open;
  logic        aclk_tick;
  pacc_src_e   src;

  // printed offsets are not all multiples of four: index times four
  assign word   = {2'b00, apb_req.paddr[7:2]};
  assign access = apb_req.psel & apb_req.penable;
  assign wr     = access & apb_req.pwrite;
  assign rd     = access & ~apb_req.pwrite;

  assign en    = st_q.ctrl[`PACC_CTRL_EN];
  assign gated = st_q.ctrl[`PACC_CTRL_MODE];
  assign pol   = st_q.ctrl[`PACC_CTRL_POL];
  assign src   = pacc_src_e'(st_q.ctrl[`PACC_CTRL_CLK_HI:`PACC_CTRL_CLK_LO]);

  // gate: polarity 0 opens on high level, 1 on low level
  assign gate_open = pol ? ~pin_level : pin_level;

  always_comb begin
    count_tick = 1'b0;
    in_event   = 1'b0;
    if (en) begin
      if (!gated) begin
        count_tick = pol ? pin_rise : pin_fall;
        in_event   = count_tick;
      end else begin
        // div64 only exists while the timer runs
        count_tick = gate_open & timer_in.div64_tick &
                     timer_in.timer_enable;
        in_event   = pol ? pin_rise : pin_fall;
      end
    end
  end

  // accum_clock: pulse whenever the accumulator advances
  assign aclk_tick = count_tick;

  always_comb begin
    // selection is combinational, so a new source applies at once
    counter_tick = timer_in.prescale_tick;
    if (en) begin
      case (src)
        PACC_SRC_PRESCALE:  counter_tick = timer_in.prescale_tick;
        PACC_SRC_ACLK:      counter_tick = aclk_tick;
        PACC_SRC_ACLK256:   counter_tick = aclk_tick &
          (st_q.div_cnt[`PACC_DIV256_BITS-1:0] == 8'hFF);
        PACC_SRC_ACLK65536: counter_tick = aclk_tick &
          (st_q.div_cnt == `PACC_COUNT_MAX);
        default:            counter_tick = timer_in.prescale_tick;
      endcase
    end
  end

  always_comb begin
    logic        ovf_set;
    logic        ffc_clr;
    logic [31:0] rdat;
    ovf_set = 1'b0;
    ffc_clr = 1'b0;
    rdat    = 32'h00000000;
    st_d    = st_q;

    // register write and count advance
    if (wr && word == `PACC_ADDR_COUNT) begin
      st_d.count = apb_req.pwdata[15:0];
    end else if (count_tick) begin
      st_d.count = st_q.count + 16'h0001;
      ovf_set    = (st_q.count == `PACC_COUNT_MAX);
    end
    if (aclk_tick) begin
      st_d.div_cnt = st_q.div_cnt + 16'h0001;
    end

    if (wr && word == `PACC_ADDR_CTRL) begin
      st_d.ctrl = apb_req.pwdata[7:0] & `PACC_CTRL_MASK;
    end

    ffc_clr = access && word == `PACC_ADDR_COUNT &&
              timer_in.fast_flag_clear;

    // flag clear by write-one, only while the timer is enabled
    if (wr && word == `PACC_ADDR_FLAGS && timer_in.timer_enable) begin
      if (apb_req.pwdata[`PACC_FLAG_OVF]) st_d.ovf = 1'b0;
      if (apb_req.pwdata[`PACC_FLAG_INF]) st_d.inf = 1'b0;
    end
    if (ffc_clr) begin
      st_d.ovf = 1'b0;
      st_d.inf = 1'b0;
    end
    // hardware set wins over any clear in the same cycle
    if (ovf_set)  st_d.ovf = 1'b1;
    if (in_event) st_d.inf = 1'b1;

    for (int i = 0; i < CHANNELS; i++) begin
      if (!channel_mode_select[i]) begin
        if (capture_strobe[i]) st_d.chan[i] = free_counter;
      end else if (wr && is_chan(word) && chan_idx(word) == i) begin
        st_d.chan[i] = apb_req.pwdata[15:0];
      end
    end

    // read data, latched into a flop
    if (word == `PACC_ADDR_CTRL) begin
      rdat[7:0] = st_q.ctrl;
    end else if (word == `PACC_ADDR_FLAGS) begin
      rdat[`PACC_FLAG_OVF] = st_q.ovf;
      rdat[`PACC_FLAG_INF] = st_q.inf;
    end else if (word == `PACC_ADDR_COUNT) begin
      rdat[15:0] = st_q.count;
    end else if (is_chan(word)) begin
      rdat[15:0] = st_q.chan[chan_idx(word)];
    end
    if (apb_req.psel && !apb_req.penable) begin
      st_d.rdata = rdat;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q.ctrl    <= `PACC_CTRL_RESET;
      st_q.ovf     <= 1'b0;
      st_q.inf     <= 1'b0;
      st_q.count   <= `PACC_COUNT_RESET;
      st_q.div_cnt <= 16'h0000;
      st_q.chan    <= '0;
      st_q.rdata   <= 32'h00000000;
    end else begin
      st_q <= st_d;
    end
  end

  always_comb begin
    for (int i = 0; i < CHANNELS; i++) begin
      compare_values[i*16 +: 16] = st_q.chan[i];
    end
  end

  // read data reflects state at setup; one access cycle, zero wait
  assign apb_rsp.pready  = 1'b1;
  assign apb_rsp.pslverr = 1'b0;
  assign apb_rsp.prdata  = st_q.rdata;

  assign accum_overflow_irq = st_q.ctrl[`PACC_CTRL_OVI] & st_q.ovf;
  assign accum_input_irq    = st_q.ctrl[`PACC_CTRL_INI] & st_q.inf;
endmodule : pacc_top

// ===== tb_top.sv
/*
  self-checking bench of pacc_top.
  assumes pready comes within seven cycles.
*/
`timescale 1ns/1ns
module tb_top;
  import pacc_pkg::*;
  logic          pclk = 1'b0;
  logic          presetn = 1'b0;
  pacc_apb_req_s req = '0;
  pacc_apb_rsp_s rsp;
  pacc_timer_s   tm = '0;
  logic [15:0]   fc = 16'h0000;
  logic [7:0]    msel = 8'hFF;
  logic [7:0]    cap = 8'h00;
  logic          pin;
  logic          tick_o;
  logic [127:0]  cv;
  logic          iov;
  logic          iin;
  logic [15:0]   v[8];
  logic [31:0]   exp_q[$];
  logic [31:0]   ticks = 32'h0;
  logic [31:0]   t0;
  // prescaler tick in its own variable: one process drives it
  logic          ptick = 1'b0;
  int            fail_count = 0;
  int            n_compared = 0;
  always #50 pclk = ~pclk;
  pacc_top u_pacc_top (.pclk(pclk), .presetn(presetn), .apb_req(req),
    .apb_rsp(rsp), .timer_in(pacc_timer_s'({tm[3:2], ptick, tm[0]})),
    .free_counter(fc),
    .channel_mode_select(msel), .capture_strobe(cap),
    .channel7_pin(pin), .counter_tick(tick_o), .compare_values(cv),
    .accum_overflow_irq(iov), .accum_input_irq(iin));
  pacc_pin_drv u_pacc_pin_drv (.pin(pin));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    int n = 0;
    req.psel   <= 1'b1;
    req.pwrite <= w;
    req.paddr  <= a;
    req.pwdata <= d;
    @(posedge pclk);
    req.penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 8);
    if (n >= 8) begin
      fail_count++;
      report_and_stop();
    end
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    xfer(1'b0, a, 32'h0);
  endtask : rd
  task automatic tick(input int n);
    repeat (n) begin
      tm.div64_tick <= 1'b1;
      @(posedge pclk);
      tm.div64_tick <= 1'b0;
      @(posedge pclk);
    end
  endtask : tick
  always @(posedge pclk) begin
    ptick <= ~ptick;
    if (req.psel && req.penable && !req.pwrite && rsp.pready === 1'b1) begin
      chk(rsp.prdata, exp_q.pop_front());
    end
    if (tick_o === 1'b1) begin
      ticks <= ticks + 32'h1;
    end
  end
  initial begin
    void'($urandom(32'h6B9A1B87));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    tm.timer_enable <= 1'b1;
    msel <= 8'($urandom) & 8'hFE;
    @(posedge pclk);
    rd(8'h80, 32'h0);
    rd(8'hFC, 32'h0);
    xfer(1'b1, 8'hFC, 32'hFFFF_FFFF);
    for (int i = 0; i < 8; i++) begin
      rd(8'h40 + 8'(4 * i), 32'h0);
      v[i] = 16'($urandom);
      xfer(1'b1, 8'h40 + 8'(4 * i), {16'h0, v[i]});
    end
    fc  <= 16'($urandom);
    cap <= ~msel;
    @(posedge pclk);
    cap <= 8'h00;
    for (int i = 0; i < 8; i++) begin
      rd(8'h40 + 8'(4 * i), {16'h0, msel[i] ? v[i] : fc});
      chk({16'h0, cv[i*16+:16]}, {16'h0, msel[i] ? v[i] : fc});
    end
    for (int p = 0; p < 2; p++) begin
      tm.timer_enable <= 1'b0;
      xfer(1'b1, 8'h80, 32'h47 | 32'(p << 4));
      xfer(1'b1, 8'h88, 32'hFFFE);
      t0 = ticks;
      u_pacc_pin_drv.pulses(3, 3 + p);
      repeat (6) @(posedge pclk);
      rd(8'h88, 32'h1);
      rd(8'h84, 32'h3);
      chk(ticks - t0, 32'h3);
      chk({30'h0, iov, iin}, 32'h3);
      xfer(1'b1, 8'h80, 32'h44 | 32'(p << 4));
      chk({30'h0, iov, iin}, 32'h0);
      // requests back on, so the flag clear below is seen at the pins
      xfer(1'b1, 8'h80, 32'h47 | 32'(p << 4));
      xfer(1'b1, 8'h84, 32'h3);
      rd(8'h84, 32'h3);
      tm.timer_enable <= 1'b1;
      xfer(1'b1, 8'h84, 32'h3);
      rd(8'h84, 32'h0);
      chk({30'h0, iov, iin}, 32'h0);
    end
    tm.fast_flag_clear <= 1'b1;
    u_pacc_pin_drv.pulses(1, 8);
    repeat (6) @(posedge pclk);
    chk({30'h0, iov, iin}, 32'h1);
    rd(8'h88, 32'h2);
    chk({30'h0, iov, iin}, 32'h0);
    rd(8'h84, 32'h0);
    tm.fast_flag_clear <= 1'b0;
    for (int p = 0; p < 2; p++) begin
      u_pacc_pin_drv.set_level(p[0]);
      @(posedge pclk);
      xfer(1'b1, 8'h80, 32'h61 | 32'(p << 4));
      xfer(1'b1, 8'h88, 32'h0);
      xfer(1'b1, 8'h84, 32'h3);
      u_pacc_pin_drv.set_level(!p[0]);
      repeat (6) @(posedge pclk);
      tick(5);
      tm.timer_enable <= 1'b0;
      tick(4);
      tm.timer_enable <= 1'b1;
      u_pacc_pin_drv.set_level(p[0]);
      repeat (6) @(posedge pclk);
      tick(3);
      rd(8'h88, 32'h5);
      rd(8'h84, 32'h1);
    end
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 8; i++) begin
      rd(8'h40 + 8'(4 * i), 32'h0);
    end
    rd(8'h88, 32'h0);
    // divide by 256 after reset; the 65536 divider needs too many edges
    xfer(1'b1, 8'h80, 32'h48);
    t0 = ticks;
    u_pacc_pin_drv.pulses(255, 3);
    repeat (6) @(posedge pclk);
    chk(ticks - t0, 32'h0);
    u_pacc_pin_drv.pulses(1, 3);
    repeat (6) @(posedge pclk);
    chk(ticks - t0, 32'h1);
    rd(8'h88, 32'h100);
    report_and_stop();
  end
endmodule : tb_top
